// ### hw/acquisition_trigger_unit.sv
// module: trigger decision, sync line handling and delay counting
//
// Summary of operation
// R1: trigger raised only in trigger state with sync line released by all.
// R2: own trigger ends our pull on sync line, its release signals all.
// R3: type 0 makes no own trigger but starts when sync is pulled/released.
// R4: host starts, waits for trigger state, then pulls sync itself.
// R5: type 1 compares raw converter samples with the sample threshold.
// R6: type 2 triggers on transitions of the front-panel trigger input.
// R7: type 3 triggers on log magnitude of the zoomed complex signal.
// R8: type 4 triggers at once on entering the trigger state.
// R9: delay counts output samples; negative keeps pre-trigger samples.
// R10: pre-trigger depth limited by buffer size per data format.
// R11: out-of-range delay flags bad parameter but is stored anyway.
// R12: sample threshold is full scale times signed level over 256.
// R13: sample comparison has hysteresis, one trigger per crossing.
// R14: magnitude threshold in 0.3762874 dB steps, level -349 to 19.
// R15: slope 0 triggers rising, slope 1 falling.
// R16: generate-enable 0 blocks own triggers, others still trigger.
// R17: all modules on the sync line start on the same trigger.
// R18: sync driven synchronously to the sample clock, off its edge.
// R19: multi-input setups use backplane ecl lines zero and one.
// R20: reset gives immediate, delay 0, levels 0 and -128, rising, gen on.
// R21: signed sample counter: post delay discards, pre delay keeps history.
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module acquisition_trigger_unit (
  // clock, reset, enable
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  // avalon-mm slave
  input  wire logic [4:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  // signal sources
  input  wire logic signed [trig_pkg::ADC_W-1:0] adc_sample,
  input  wire logic                         adc_valid,
  input  wire logic signed [15:0]           mag_log,
  input  wire logic                         mag_valid,
  input  wire logic                         ext_trig_in,
  input  wire logic                         out_valid,
  // shared sync line, open collector
  input  wire logic                         sync_in, // R19
  output logic                              sync_out,
  output logic                              sync_oe,
  // buffer control
  output logic                              store_enable,
  output logic                              record_start,
  output logic      [trig_pkg::CNT_W-1:0]   rewind_count
);

  // ==========================================================
  // settings and state
  trig_pkg::trig_cfg_t   cfg;
  trig_pkg::meas_state_t state;
  logic signed [31:0]    delay;
  logic signed [8:0]     adclevel;
  logic signed [9:0]     maglevel;
  logic                  line_pull;
  logic                  bad_param;
  logic                  trigd;
  logic                  ack;
  logic                  hold;
  logic                  own_done;
  logic                  saw_low;
  logic                  adc_armed;
  logic                  mag_armed;
  logic                  ext_prev;
  logic [trig_pkg::CNT_W-1:0] cnt;
  logic [trig_pkg::CNT_W-1:0] hist;

  // ==========================================================
  // bus decode
  wire access   = avs_read | avs_write;
  wire wr       = avs_write & ack & ce;
  wire wr_ctrl  = wr & (avs_address == trig_pkg::OFS_CTRL);
  wire wr_delay = wr & (avs_address == trig_pkg::OFS_DELAY);
  wire wr_adc   = wr & (avs_address == trig_pkg::OFS_ADCLVL);
  wire wr_mag   = wr & (avs_address == trig_pkg::OFS_MAGLVL);
  wire wr_stat  = wr & (avs_address == trig_pkg::OFS_STATUS);
  wire cmd_begin = wr_ctrl & avs_writedata[trig_pkg::CTRL_BEGIN];
  wire cmd_stop  = wr_ctrl & avs_writedata[trig_pkg::CTRL_STOP];
  wire signed [31:0] wdata_s = avs_writedata;
  // begin uses the fields written with it, not the old settings
  wire [2:0] new_type = avs_writedata[trig_pkg::CTRL_TYPE_LSB +: 3];
  wire       new_gen  = avs_writedata[trig_pkg::CTRL_GEN];
  wire       new_own  = new_gen & (new_type != trig_pkg::TYPE_USER) &
                        (new_type != trig_pkg::TYPE_IMM);

  // waitrequest drops one cycle after a request appears
  assign avs_waitrequest = access & ~ack;

  // ==========================================================
  // helpers
  function automatic logic slope_hit(input logic armed, input logic above,
                                     input logic slope);
    slope_hit = armed & (slope ? ~above : above); // R15
  endfunction : slope_hit

  function automatic logic signed [31:0] pre_limit(input logic [1:0] fmt);
    case (fmt)
      trig_pkg::FMT_C32: pre_limit = trig_pkg::PRE_C32;
      trig_pkg::FMT_R32: pre_limit = trig_pkg::PRE_R32;
      default:           pre_limit = trig_pkg::PRE_R16;
    endcase
  endfunction : pre_limit

  // delay range check against the widest format limit
  wire delay_bad = (wdata_s < trig_pkg::PRE_C32) |
                   (wdata_s > trig_pkg::POST_MAX); // R11

  // ==========================================================
  // thresholds
  wire signed [trig_pkg::ADC_W-1:0] adc_thr =
    trig_pkg::ADC_W'(adclevel) <<< trig_pkg::LVL_SH; // R12
  wire signed [trig_pkg::ADC_W:0] adc_x   =
    (trig_pkg::ADC_W+1)'(adc_sample);
  wire signed [trig_pkg::ADC_W:0] adc_t   = (trig_pkg::ADC_W+1)'(adc_thr);
  wire signed [trig_pkg::ADC_W:0] adc_h   =
    (trig_pkg::ADC_W+1)'(trig_pkg::ADC_HYST);
  wire adc_above = adc_x >= adc_t;
  wire adc_below = adc_x <  adc_t - adc_h;
  wire adc_high  = adc_x >  adc_t + adc_h;
  wire signed [15:0] mag_thr = 16'(maglevel); // R14
  wire mag_above = mag_log >= mag_thr;
  wire mag_below = mag_log <  mag_thr - trig_pkg::MAG_HYST;
  wire mag_high  = mag_log >  mag_thr + trig_pkg::MAG_HYST;

  // event per source, all gated by slope
  wire adc_ev = adc_valid & slope_hit(adc_armed, adc_above,
                                      cfg.slope); // R5 R13
  wire mag_ev = mag_valid & slope_hit(mag_armed, mag_above, cfg.slope); // R7
  wire ext_ev = (ext_trig_in != ext_prev) &
                (cfg.slope ? ~ext_trig_in : ext_trig_in); // R6 R15

  // selected own event
  wire own_ev = (cfg.ttype == trig_pkg::TYPE_ADC) ? adc_ev :
                (cfg.ttype == trig_pkg::TYPE_EXT) ? ext_ev :
                (cfg.ttype == trig_pkg::TYPE_MAG) ? mag_ev : 1'b0; // R3

  // ==========================================================
  // trigger decision on the shared line
  wire in_trig   = state == trig_pkg::ST_TRIG;
  wire can_gen   = cfg.gen & (cfg.ttype != trig_pkg::TYPE_USER); // R16
  wire fire = in_trig & sync_in & ~sync_oe & (own_done | saw_low); // R1 R17
  wire signed [31:0] lim   = pre_limit(cfg.fmt);
  wire signed [31:0] eff_d = (delay < lim) ? lim : delay; // R10
  wire [31:0] pre_depth    = 32'(-eff_d);
  wire pre_mode = eff_d < 0;

  // line driven only from clocked state, so it moves right after mclk
  assign sync_out = 1'b0;
  assign sync_oe  = (in_trig & hold) | line_pull; // R2 R18

  // ==========================================================
  // register writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg      <= trig_pkg::CFG_RST; // R20
      delay    <= trig_pkg::DELAY_RST;
      adclevel <= trig_pkg::ADCLVL_RST;
      maglevel <= trig_pkg::MAGLVL_RST;
      line_pull <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        cfg.ttype <= avs_writedata[trig_pkg::CTRL_TYPE_LSB +: 3];
        cfg.slope <= avs_writedata[trig_pkg::CTRL_SLOPE];
        cfg.gen   <= avs_writedata[trig_pkg::CTRL_GEN];
        cfg.fmt   <= avs_writedata[trig_pkg::CTRL_FMT_LSB +: 2];
        line_pull <= avs_writedata[trig_pkg::CTRL_LINE]; // R4
      end
      if (wr_delay)
        delay <= wdata_s; // R11
      if (wr_adc)
        adclevel <= avs_writedata[8:0];
      if (wr_mag)
        maglevel <= avs_writedata[9:0];
    end
  end

  // ==========================================================
  // bus answer and sticky flags, set wins over clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack       <= 1'b0;
      bad_param <= 1'b0;
      trigd     <= 1'b0;
    end else if (ce) begin
      ack <= access & ~ack;
      if (wr_delay & delay_bad)
        bad_param <= 1'b1; // R11
      else if (wr_stat & avs_writedata[trig_pkg::STAT_BADPAR])
        bad_param <= 1'b0;
      if (fire)
        trigd <= 1'b1;
      else if (wr_stat & avs_writedata[trig_pkg::STAT_TRIGD])
        trigd <= 1'b0;
    end
  end

  // read data mux
  wire [31:0] rd_ctrl = {21'h0, 1'b0, line_pull, 2'h0, cfg.fmt, cfg.gen,
                         cfg.slope, cfg.ttype};
  wire [31:0] rd_stat = {22'h0, trigd, bad_param, 4'h0, state};
  wire [31:0] rd_mux =
    (avs_address == trig_pkg::OFS_CTRL)   ? rd_ctrl :
    (avs_address == trig_pkg::OFS_DELAY)  ? delay :
    (avs_address == trig_pkg::OFS_ADCLVL) ? 32'(adclevel) :
    (avs_address == trig_pkg::OFS_MAGLVL) ? 32'(maglevel) :
    (avs_address == trig_pkg::OFS_STATUS) ? rd_stat : 32'h0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      avs_readdata <= 32'h0;
    else if (ce & avs_read & ~ack)
      avs_readdata <= rd_mux;
  end

  // ==========================================================
  // source edge trackers, hysteresis re-arm for sample and magnitude
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      adc_armed <= 1'b0;
      mag_armed <= 1'b0;
      ext_prev  <= 1'b0;
    end else if (ce) begin
      ext_prev <= ext_trig_in;
      if (adc_valid)
        adc_armed <= adc_ev ? 1'b0 :
                     (cfg.slope ? adc_high : adc_below) | adc_armed; // R13
      if (mag_valid)
        mag_armed <= mag_ev ? 1'b0 :
                     (cfg.slope ? mag_high : mag_below) | mag_armed;
    end
  end

  // ==========================================================
  // measurement state machine and delay counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state        <= trig_pkg::ST_IDLE;
      hold         <= 1'b0;
      own_done     <= 1'b0;
      saw_low      <= 1'b0;
      cnt          <= '0;
      hist         <= '0;
      record_start <= 1'b0;
      rewind_count <= '0;
    end else if (ce) begin
      record_start <= 1'b0;
      if (cmd_stop) begin
        state <= trig_pkg::ST_IDLE;
        hold  <= 1'b0;
      end else if (cmd_begin) begin
        state    <= trig_pkg::ST_TRIG;
        hold     <= new_own; // R2
        own_done <= new_gen & (new_type == trig_pkg::TYPE_IMM); // R8
        saw_low  <= 1'b0;
        hist     <= '0;
      end else begin
        case (state)
          trig_pkg::ST_IDLE: begin
            hold <= 1'b0;
          end
          trig_pkg::ST_TRIG: begin
            if (~sync_in)
              saw_low <= 1'b1; // R3
            if (hold & can_gen & own_ev) begin
              hold     <= 1'b0; // R2
              own_done <= 1'b1;
            end
            if (pre_mode & out_valid & (hist < pre_depth))
              hist <= hist + 32'h1; // R21
            if (fire) begin
              hold <= 1'b0;
              if (eff_d > 0) begin
                state <= trig_pkg::ST_POST;
                cnt   <= 32'(eff_d); // R9
              end else begin
                state        <= trig_pkg::ST_COLL;
                record_start <= 1'b1;
                rewind_count <= pre_mode ? hist : 32'h0; // R9 R10
              end
            end
          end
          trig_pkg::ST_POST: begin
            if (out_valid) begin
              cnt <= cnt - 32'h1; // R21
              if (cnt == 32'h1) begin
                state        <= trig_pkg::ST_COLL;
                record_start <= 1'b1;
                rewind_count <= 32'h0;
              end
            end
          end
          trig_pkg::ST_COLL: begin
            hold <= 1'b0;
          end
          default: begin
            state <= trig_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // buffer writes: history while waiting in pre mode, then the record
  assign store_enable = (state == trig_pkg::ST_COLL) |
                        (in_trig & pre_mode); // R21

endmodule : acquisition_trigger_unit

// ### hw/trig_pkg.sv
// package: constants and types of the acquisition trigger unit
package trig_pkg;

  // ==========================================================
  // register map (byte offsets on the avalon slave)
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_DELAY  = 5'h04;
  localparam logic [4:0] OFS_ADCLVL = 5'h08;
  localparam logic [4:0] OFS_MAGLVL = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  // control fields
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_SLOPE    = 3;
  localparam int CTRL_GEN      = 4;
  localparam int CTRL_FMT_LSB  = 5;
  localparam int CTRL_BEGIN    = 8;
  localparam int CTRL_LINE     = 9;
  localparam int CTRL_STOP     = 10;

  // status fields
  localparam int STAT_BADPAR = 8;
  localparam int STAT_TRIGD  = 9;

  // ==========================================================
  // trigger types, formats and widths
  localparam logic [2:0] TYPE_USER = 3'h0;
  localparam logic [2:0] TYPE_ADC  = 3'h1;
  localparam logic [2:0] TYPE_EXT  = 3'h2;
  localparam logic [2:0] TYPE_MAG  = 3'h3;
  localparam logic [2:0] TYPE_IMM  = 3'h4;
  localparam logic [1:0] FMT_C32   = 2'h0;
  localparam logic [1:0] FMT_R32   = 2'h1;
  localparam logic [1:0] FMT_R16   = 2'h2;
  localparam int ADC_W  = 24;
  localparam int LVL_SH = ADC_W - 9;
  localparam int CNT_W  = 32;

  // ==========================================================
  // delay limits and hysteresis, buffer of eight megabytes
  localparam logic signed [31:0] BUFFER_BYTES = 32'sh0080_0000;
  localparam logic signed [31:0] POST_MAX  = 32'sh00ff_ff9c;
  localparam logic signed [31:0] PRE_C32 = 32'sh0000_0084 - BUFFER_BYTES / 8;
  localparam logic signed [31:0] PRE_R32 = 32'sh0000_00a4 - BUFFER_BYTES / 4;
  localparam logic signed [31:0] PRE_R16 = 32'sh0000_00e4 - BUFFER_BYTES / 2;
  localparam logic signed [ADC_W-1:0] ADC_HYST = 24'sh00_4000;
  localparam logic signed [15:0] MAG_HYST = 16'sh0002;

  // ==========================================================
  // reset values
  localparam logic signed [8:0] ADCLVL_RST = 9'sh000;
  localparam logic signed [9:0] MAGLVL_RST = -10'sd128;
  localparam logic signed [31:0] DELAY_RST = 32'sh0000_0000;

  typedef struct packed {
    logic [1:0] fmt;
    logic       gen;
    logic       slope;
    logic [2:0] ttype;
  } trig_cfg_t;

  localparam trig_cfg_t CFG_RST = '{fmt: 2'h0, gen: 1'b1, slope: 1'b0,
                                     ttype: 3'h4};

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_TRIG = 4'h2,
    ST_POST = 4'h4,
    ST_COLL = 4'h8
  } meas_state_t;

endpackage : trig_pkg

// ### verification/sync_peer.sv
// partner: peer module on the shared open-collector sync line
`timescale 1ns/1ps
module sync_peer (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // bench command and the unit's drive
  input  wire logic pull_req,
  input  wire logic sync_oe,
  input  wire logic sync_out,
  // resolved line level
  output logic      sync_line
);
  logic peer_pull;
  // pull changes just after the common clock edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      peer_pull <= 1'b0;
    end else begin
      peer_pull <= pull_req;
    end
  end
  // pull-up: line high unless some party pulls it low
  assign sync_line = (sync_oe ? sync_out : 1'b1) & ~peer_pull;
endmodule : sync_peer

// ### verification/tb.sv
// bench: register and trigger scenarios for the trigger unit
`timescale 1ns/1ps
module tb;
  logic               mclk, rst, rd_req, wr_req, ext, ov, av, pull, mv;
  logic signed [15:0] mlog;
  logic [4:0]         addr;
  logic [31:0]        wdat, rdat, got, rw, rew;
  logic signed [23:0] smp;
  logic               wait_rq, line, soe, sout, stor, rstart;
  int                 error_cnt, n_compared;
  logic [31:0]        dv [4] = '{32'h00ffff9c, 32'hfff00084,
                                 32'h00ffff9d, 32'hfff00083};

  acquisition_trigger_unit i_acquisition_trigger_unit (
    .mclk(mclk), .rst(rst), .ce(1'b1), .avs_address(addr),
    .avs_read(rd_req), .avs_write(wr_req), .avs_writedata(wdat),
    .avs_readdata(rdat), .avs_waitrequest(wait_rq), .adc_sample(smp),
    .adc_valid(av), .mag_log(mlog), .mag_valid(mv),
    .ext_trig_in(ext), .out_valid(ov), .sync_in(line), .sync_out(sout),
    .sync_oe(soe), .store_enable(stor), .record_start(rstart),
    .rewind_count(rew));
  sync_peer i_sync_peer (.mclk(mclk), .rst(rst), .pull_req(pull),
    .sync_oe(soe), .sync_out(sout), .sync_line(line));

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one bus cycle, held until wait request is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    addr   <= a;
    wdat   <= d;
    wr_req <= w;
    rd_req <= !w;
    do @(posedge mclk); while (wait_rq !== 1'b0);
    got = rdat;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
  endtask : bus
  task automatic rchk(input string nm, input logic [4:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, got);
  endtask : rchk
  // look for a start pulse within lim cycles, keep its rewind count
  task automatic wait_start(input int lim);
    got = 32'h0;
    repeat (lim) begin
      @(posedge mclk);
      if (rstart === 1'b1) begin
        got = 32'h1;
        rw = rew;
        break;
      end
    end
  endtask : wait_start
  task automatic pulse(input int n, input logic adc, input logic [23:0] v);
    repeat (n) begin
      @(posedge mclk);
      smp <= v;
      if (adc) av <= 1'b1;
      else ov <= 1'b1;
      @(posedge mclk);
      av <= 1'b0;
      ov <= 1'b0;
    end
  endtask : pulse
  task automatic report_and_stop;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // clock, watchdog and scenarios
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {rst, rd_req, wr_req, ext, ov, av, pull, mv} = 8'h80;
    mlog = 16'sh0;
    addr = 5'h00;
    wdat = 32'h0;
    smp = 24'sh0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rchk("ctrl", 5'h00, 32'h14);
    rchk("delay", 5'h04, 32'h0);
    rchk("adclvl", 5'h08, 32'h0);
    rchk("maglvl", 5'h0c, 32'hffffff80);
    rchk("status", 5'h10, 32'h1);
    bus(1'b1, 5'h14, 32'hffffffff);
    rchk("unmapped", 5'h14, 32'h0);
    for (int t = 0; t < 5; t++) begin
      bus(1'b1, 5'h00, 32'(t) | 32'h8);
      rchk("type", 5'h00, 32'(t) | 32'h8);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 5'h04, dv[i]);
      rchk("delay", 5'h04, dv[i]);
      rchk("status", 5'h10, i < 2 ? 32'h1 : 32'h101);
      bus(1'b1, 5'h10, 32'h100);
    end
    // immediate start, first while a peer holds the line low
    bus(1'b1, 5'h04, 32'h0);
    pull <= 1'b1;
    bus(1'b1, 5'h00, 32'h114);
    wait_start(8);
    chk("held start", 32'h0, got);
    pull <= 1'b0;
    wait_start(8);
    chk("imm start", 32'h1, got);
    chk("rewind", 32'h0, rw);
    rchk("status", 5'h10, 32'h208);
    // host-forced start under type 0 with pre-trigger history
    bus(1'b1, 5'h04, 32'hfffffffe);
    bus(1'b1, 5'h00, 32'h110);
    wait_start(20);
    chk("user idle", 32'h0, got);
    pulse(4, 1'b0, 24'h0);
    chk("pre store", 32'h1, 32'(stor));
    bus(1'b1, 5'h00, 32'h210);
    wait_start(6);
    chk("pulled", 32'h0, got);
    bus(1'b1, 5'h00, 32'h010);
    wait_start(8);
    chk("user start", 32'h1, got);
    chk("rewind", 32'h2, rw);
    // post-trigger delay of three output samples
    bus(1'b1, 5'h04, 32'h3);
    bus(1'b1, 5'h00, 32'h114);
    pulse(2, 1'b0, 24'h0);
    chk("post store", 32'h0, 32'(stor));
    wait_start(3);
    chk("post early", 32'h0, got);
    pulse(1, 1'b0, 24'h0);
    wait_start(3);
    chk("post start", 32'h1, got);
    // front-panel input, both slopes, wrong edge first
    bus(1'b1, 5'h04, 32'h0);
    for (int s = 0; s < 2; s++) begin
      ext <= !s[0];
      bus(1'b1, 5'h00, 32'h112 | (32'(s) << 3));
      repeat (3) @(posedge mclk);
      chk("own pull", 32'h1, 32'(soe));
      ext <= s[0];
      wait_start(6);
      chk("wrong edge", 32'h0, got);
      ext <= !s[0];
      wait_start(6);
      chk("ext start", 32'h1, got);
    end
    // generation off: own edges ignored, a peer still starts us
    bus(1'b1, 5'h00, 32'h102);
    repeat (3) @(posedge mclk);
    chk("no pull", 32'h0, 32'(soe));
    ext <= 1'b0;
    repeat (2) @(posedge mclk);
    ext <= 1'b1;
    wait_start(6);
    chk("gen off", 32'h0, got);
    pull <= 1'b1;
    repeat (3) @(posedge mclk);
    pull <= 1'b0;
    wait_start(8);
    chk("peer start", 32'h1, got);
    // raw sample threshold at level 1, i.e. 0x8000
    bus(1'b1, 5'h08, 32'h1);
    rchk("adclvl", 5'h08, 32'h1);
    bus(1'b1, 5'h00, 32'h111);
    pulse(2, 1'b1, 24'hff0000);
    pulse(2, 1'b1, 24'h007000);
    wait_start(4);
    chk("below level", 32'h0, got);
    pulse(1, 1'b1, 24'h020000);
    wait_start(6);
    chk("adc start", 32'h1, got);
    // magnitude level -100: arm below it, then rise through it
    bus(1'b1, 5'h0c, 32'hffffff9c);
    rchk("maglvl", 5'h0c, 32'hffffff9c);
    bus(1'b1, 5'h00, 32'h113);
    mlog <= 16'hff92;
    mv   <= 1'b1;
    wait_start(4);
    chk("mag below", 32'h0, got);
    mlog <= 16'hff9c;
    wait_start(4);
    chk("mag start", 32'h1, got);
    mv <= 1'b0;
    report_and_stop();
  end
endmodule : tb

bind acquisition_trigger_unit trig_asserts i_trig_asserts (
  .mclk(mclk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .out_valid(out_valid),
  .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
  .store_enable(store_enable), .record_start(record_start));

// ### verification/trig_asserts.sv
// checker: port assertions of the acquisition trigger unit
`timescale 1ns/1ps
module trig_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // samples, sync line and buffer control
  input wire logic out_valid,
  input wire logic sync_in,
  input wire logic sync_out,
  input wire logic sync_oe,
  input wire logic store_enable,
  input wire logic record_start
);
  // ==========================================================
  // checks, all in the sample clock domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_start_pulse: assert property (record_start |=> !record_start)
    else $error("record start longer than one cycle");
  a_start_stores: assert property (record_start |-> store_enable)
    else $error("record start without storing");
  a_reset_quiet: assert property ($fell(rst) |->
    !sync_oe && !store_enable && !record_start)
    else $error("outputs active right after reset");
  a_fire_release: assert property (record_start && !$past(out_valid)
    |-> $past(sync_in) && !$past(sync_oe))
    else $error("trigger while sync line pulled");
  a_start_no_pull: assert property (record_start |-> !sync_oe)
    else $error("sync line still pulled after trigger");
  a_sync_low_only: assert property (!sync_out)
    else $error("sync line driven high");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  a_idle_nowait: assert property (!(avs_read || avs_write)
    |-> !avs_waitrequest)
    else $error("wait request without a request");
  c_start: cover property (record_start);
  c_release: cover property ($fell(sync_oe));
  c_read_wait: cover property (avs_read && avs_waitrequest);
endmodule : trig_asserts
